// ### common/trs_pkg.sv
package trs_pkg;

  // ----------------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite slave.
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [1:0] GPR_PAGE = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int FLAG_LSB = 28;
  localparam int STAT_BUSY = 0;
  localparam int STAT_UNDEF = 1;
  localparam int STAT_EVENT = 2;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [3:0] SP_IDX = 4'hd;
  localparam int WORD_SHIFT = 2;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // ----------------------------------------------------------------------
  // Opcode patterns.
  // ----------------------------------------------------------------------
  localparam logic [9:0] OPC_ROR = 10'h107;
  localparam logic [9:0] OPC_RSB = 10'h109;
  localparam logic [9:0] OPC_SBC = 10'h106;
  localparam logic [15:0] OPC_SEV = 16'hbf40;
  localparam logic [4:0] OPC_STM = 5'h18;
  localparam logic [4:0] OPC_STR_REG_BASE = 5'h0c;
  localparam logic [4:0] OPC_STR_SP_BASE = 5'h12;

  typedef enum logic [1:0] {
    ALU_ROR = 2'b00,
    ALU_RSB = 2'b01,
    ALU_SBC = 2'b10
  } trs_alu_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_STORE = 2'b10
  } trs_state_e;

endpackage

// ### logic/trs_alu.sv
`timescale 1ns/1ps
`default_nettype none

module trs_alu (
  input wire trs_pkg::trs_alu_op_e op,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic [3:0] nzcv_in,
  output logic [31:0] result,
  output logic [3:0] nzcv_out
);

  // ----------------------------------------------------------------------
  // Rotator and shared adder.
  // ----------------------------------------------------------------------
  wire logic [7:0] rot_amt = op_b[7:0];
  wire logic [4:0] rot_mod = rot_amt[4:0];
  wire logic [63:0] rot_dbl = {op_a, op_a} >> rot_mod;
  wire logic [31:0] rot_res = (rot_amt == 8'h00) ? op_a : rot_dbl[31:0];
  wire logic rot_c = (rot_amt == 8'h00) ? nzcv_in[1] : rot_res[31];

  // One adder serves both subtracts, so the carry and overflow logic is shared.
  wire logic is_rsb = (op == trs_pkg::ALU_RSB);
  wire logic [31:0] add_x = is_rsb ? ~op_a : op_a;
  wire logic [31:0] add_y = is_rsb ? 32'h0000_0000 : ~op_b;
  wire logic add_ci = is_rsb ? 1'b1 : nzcv_in[1];
  wire logic [32:0] add_sum = {1'b0, add_x} + {1'b0, add_y} + {32'h0000_0000, add_ci};
  wire logic add_v = (add_x[31] == add_y[31]) && (add_sum[31] != add_x[31]);

  assign result = (op == trs_pkg::ALU_ROR) ? rot_res : add_sum[31:0];

  // N, Z, C, V; the rotate keeps V.
  assign nzcv_out = (op == trs_pkg::ALU_ROR) ?
      {rot_res[31], rot_res == 32'h0000_0000, rot_c, nzcv_in[0]} :
      {add_sum[31], add_sum[31:0] == 32'h0000_0000, add_sum[32], add_v};

endmodule // trs_alu

`default_nettype wire

// ### logic/trs_exec.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Rotate right moves bits leaving the bottom back into the top.
// - Rotate amount is the unsigned bottom byte of the second operand register.
// - Rotate writes destination; N from bit 31, Z on zero, C carry, V kept.
// - Reverse subtract adds inverted source, zero and carry-in one; result to destination.
// - Reverse subtract immediate is zero; N, Z, C, V from the adder.
// - Subtract with borrow adds first, inverted second and carry; updates all flags.
// - Rotate and borrow subtract share one field for destination and first source.
// - Send-event hint pulses the event output and sets the status event bit.
// - Send-event hint leaves registers and memory untouched, like a no-operation.
// - Store multiple writes listed registers, lowest first, at ascending word addresses.
// - Store multiple writes back base plus four times the register count.
// - Base in list but not lowest may store an arbitrary value.
// - Word store address is base plus scaled zero-extended offset; base unchanged.
// - General-base form offset is the five-bit field times four, 0 to 124.
// - Stack form uses register 13 and the eight-bit field times four.
// - Both word store forms pre-index, always add, never write back.
// - Flag-setting forms always update flags, there being no conditional block.

module trs_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic event_out
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic [31:0] gpr [16];
  logic [15:0] instr;
  logic [3:0] nzcv;
  logic undef;
  logic event_seen;
  logic [7:0] stm_rem;
  trs_pkg::trs_state_e state;
  logic aw_got;
  logic w_got;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ----------------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------------
  wire logic is_ror = (instr[15:6] == trs_pkg::OPC_ROR);
  wire logic is_rsb = (instr[15:6] == trs_pkg::OPC_RSB);
  wire logic is_sbc = (instr[15:6] == trs_pkg::OPC_SBC);
  wire logic is_sev = (instr == trs_pkg::OPC_SEV);
  wire logic is_stm = (instr[15:11] == trs_pkg::OPC_STM);
  wire logic is_str1 = (instr[15:11] == trs_pkg::OPC_STR_REG_BASE);
  wire logic is_str2 = (instr[15:11] == trs_pkg::OPC_STR_SP_BASE);
  wire logic is_alu = is_ror || is_rsb || is_sbc;
  wire logic [3:0] rd_lo = {1'b0, instr[2:0]};
  wire logic [3:0] rs_mid = {1'b0, instr[5:3]};
  wire logic [3:0] stm_base = {1'b0, instr[10:8]};
  wire logic [3:0] str2_src = {1'b0, instr[10:8]};

  // Rotate and borrow subtract take the first operand from the low field; reverse subtract reads the middle.
  wire logic [31:0] alu_a = is_rsb ? gpr[rs_mid] : gpr[rd_lo];
  wire logic [31:0] alu_b = gpr[rs_mid];
  wire trs_pkg::trs_alu_op_e alu_op = is_ror ? trs_pkg::ALU_ROR :
      (is_rsb ? trs_pkg::ALU_RSB : trs_pkg::ALU_SBC);
  logic [31:0] alu_res;
  logic [3:0] alu_nzcv;

  trs_alu u_alu (
    .op(alu_op),
    .op_a(alu_a),
    .op_b(alu_b),
    .nzcv_in(nzcv),
    .result(alu_res),
    .nzcv_out(alu_nzcv)
  );

  // ----------------------------------------------------------------------
  // Store address forming.
  // ----------------------------------------------------------------------
  wire logic [31:0] off1 = 32'(instr[10:6]) << trs_pkg::WORD_SHIFT;
  wire logic [31:0] off2 = 32'(instr[7:0]) << trs_pkg::WORD_SHIFT;
  wire logic [31:0] str1_addr = gpr[rs_mid] + off1;
  wire logic [31:0] str2_addr = gpr[trs_pkg::SP_IDX] + off2;
  wire logic [31:0] str_addr = is_str2 ? str2_addr : str1_addr;
  wire logic [31:0] str_data = is_str2 ? gpr[str2_src] : gpr[rd_lo];

  // Lowest remaining list entry; the list walk starts from the full field.
  wire logic [7:0] stm_pick_src = (state == trs_pkg::ST_EXEC) ? instr[7:0] : stm_rem;
  logic [2:0] stm_low;
  always_comb begin
    stm_low = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (stm_pick_src[i]) begin
        stm_low = 3'(i);
      end
    end
  end
  wire logic [7:0] stm_left = stm_pick_src & ~(8'h01 << stm_low);
  // A base register listed above the lowest entry is stored as it stands now;
  // any value is acceptable there, so no special path is spent on it.
  wire logic [31:0] stm_word = gpr[{1'b0, stm_low}];

  // ----------------------------------------------------------------------
  // Register bus decode.
  // ----------------------------------------------------------------------
  wire logic idle = (state == trs_pkg::ST_IDLE);
  wire logic wr_do = aw_got && w_got && !s_axi_bvalid;
  wire logic wr_is_gpr = (wr_addr[7:6] == trs_pkg::GPR_PAGE);
  wire logic wr_is_instr = (wr_addr == trs_pkg::OFF_INSTR);
  wire logic wr_is_flags = (wr_addr == trs_pkg::OFF_FLAGS);
  wire logic wr_is_status = (wr_addr == trs_pkg::OFF_STATUS);
  wire logic wr_ok = wr_is_gpr || wr_is_instr || wr_is_flags || wr_is_status;
  wire logic [31:0] flags_word = {nzcv, 28'h000_0000};
  wire logic [31:0] status_word = {29'h0000_0000, event_seen, undef, !idle};
  wire logic [31:0] wr_old = wr_is_gpr ? gpr[wr_addr[5:2]] :
      (wr_is_flags ? flags_word : {16'h0000, instr});
  logic [31:0] wr_merge;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merge[8*b +: 8] = wr_strb[b] ? wr_data[8*b +: 8] : wr_old[8*b +: 8];
  end
  // Writes that would disturb an instruction in flight are dropped.
  wire logic wr_gpr_en = wr_do && wr_is_gpr && idle;
  wire logic wr_flags_en = wr_do && wr_is_flags && idle;
  wire logic launch = wr_do && wr_is_instr && idle;

  wire logic rd_is_gpr = (s_axi_araddr[7:6] == trs_pkg::GPR_PAGE);
  wire logic rd_ok = rd_is_gpr || (s_axi_araddr == trs_pkg::OFF_INSTR) ||
      (s_axi_araddr == trs_pkg::OFF_STATUS) || (s_axi_araddr == trs_pkg::OFF_FLAGS);
  wire logic [31:0] rd_word = rd_is_gpr ? gpr[s_axi_araddr[5:2]] :
      (s_axi_araddr == trs_pkg::OFF_INSTR) ? {16'h0000, instr} :
      (s_axi_araddr == trs_pkg::OFF_STATUS) ? status_word :
      (s_axi_araddr == trs_pkg::OFF_FLAGS) ? flags_word : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Register file write port.
  // ----------------------------------------------------------------------
  wire logic exec_now = (state == trs_pkg::ST_EXEC);
  wire logic store_ack = (state == trs_pkg::ST_STORE) && mem_ready;
  wire logic alu_we = exec_now && is_alu;
  wire logic stm_last = store_ack && is_stm && (stm_rem == 8'h00);
  // The address after the last word equals base plus four per listed register.
  wire logic [31:0] stm_wb = mem_addr + trs_pkg::WORD_STEP;
  wire logic ex_we = alu_we || stm_last;
  wire logic [3:0] ex_idx = stm_last ? stm_base : rd_lo;
  wire logic [31:0] ex_val = stm_last ? stm_wb : alu_res;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= trs_pkg::GPR_RESET;
      end
    end else if (wr_gpr_en) begin
      gpr[wr_addr[5:2]] <= wr_merge;
    end else if (ex_we) begin
      gpr[ex_idx] <= ex_val;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction, flags and status.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= trs_pkg::INSTR_RESET;
      nzcv <= trs_pkg::FLAGS_RESET;
      undef <= 1'b0;
      event_seen <= 1'b0;
    end else begin
      if (launch) begin
        instr <= wr_merge[15:0];
      end
      if (wr_flags_en) begin
        nzcv <= wr_merge[31:trs_pkg::FLAG_LSB];
      end else if (alu_we) begin
        nzcv <= alu_nzcv;
      end
      if (exec_now) begin
        undef <= !(is_alu || is_sev || is_stm || is_str1 || is_str2);
      end
      // The event record is sticky; a status write with the event bit set clears it unless an event lands.
      if (exec_now && is_sev) begin
        event_seen <= 1'b1;
      end else if (wr_do && wr_is_status && wr_strb[0] && wr_data[trs_pkg::STAT_EVENT]) begin
        event_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer and memory port.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= trs_pkg::ST_IDLE;
      stm_rem <= 8'h00;
      mem_valid <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      event_out <= 1'b0;
    end else begin
      event_out <= exec_now && is_sev;
      unique case (state)
        trs_pkg::ST_IDLE: begin
          if (launch) begin
            state <= trs_pkg::ST_EXEC;
          end
        end
        trs_pkg::ST_EXEC: begin
          state <= trs_pkg::ST_IDLE;
          if (is_str1 || is_str2) begin
            mem_addr <= str_addr;
            mem_wdata <= str_data;
            mem_valid <= 1'b1;
            state <= trs_pkg::ST_STORE;
          end else if (is_stm && (instr[7:0] != 8'h00)) begin
            mem_addr <= gpr[stm_base];
            mem_wdata <= stm_word;
            stm_rem <= stm_left;
            mem_valid <= 1'b1;
            state <= trs_pkg::ST_STORE;
          end
        end
        trs_pkg::ST_STORE: begin
          if (mem_ready) begin
            if (is_stm && (stm_rem != 8'h00)) begin
              mem_addr <= mem_addr + trs_pkg::WORD_STEP;
              mem_wdata <= stm_word;
              stm_rem <= stm_left;
            end else begin
              mem_valid <= 1'b0;
              state <= trs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= trs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write channels.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= trs_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? trs_pkg::RESP_OKAY : trs_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channels.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= trs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? trs_pkg::RESP_OKAY : trs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // trs_exec

`default_nettype wire

// ### dv/trs_exec_props.sv
`timescale 1ns/1ps
`default_nettype none

module trs_exec_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic event_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_ev_pulse;
    event_out |=> !event_out;
  endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event pulse too long");
  property p_ev_cause;
    event_out |-> $past(s_axi_bvalid);
  endproperty
  a_ev_cause: assert property (p_ev_cause) else $error("event without launch");
  property p_ev_quiet;
    event_out |-> !mem_valid;
  endproperty
  a_ev_quiet: assert property (p_ev_quiet) else $error("store during event");
  property p_st_hold;
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_wdata);
  endproperty
  a_st_hold: assert property (p_st_hold) else $error("store dropped or changed");
  property p_stm_step;
    mem_valid && mem_ready ##1 mem_valid |-> mem_addr == $past(mem_addr) + 32'h0000_0004;
  endproperty
  a_stm_step: assert property (p_stm_step) else $error("store step not one word");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken before response");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read response late");
endmodule // trs_exec_chk

bind trs_exec trs_exec_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .event_out(event_out));

`default_nettype wire

// ### dv/trs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// Word store sink; each store waits one cycle more than stall before it is taken.
module trs_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] stall
);
  logic [3:0] wait_cnt;
  logic [31:0] addr_q[$];
  logic [31:0] data_q[$];

  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (mem_valid && mem_ready) begin
      addr_q.push_back(mem_addr);
      data_q.push_back(mem_wdata);
      mem_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (mem_valid && wait_cnt >= stall) begin
      mem_ready <= 1'b1;
    end else if (mem_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // trs_mem_model

`default_nettype wire

// ### dv/trs_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module trs_exec_tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, mem_wdata, v;
  logic [1:0] bresp, rresp, r;
  logic mem_valid, mem_ready, event_out;
  logic [3:0] stall;
  int n_fail, checked, ev_cnt;
  // ALU cases: instruction, flags before, register to read, value and flags after.
  localparam logic [15:0] INS [7] = '{{trs_pkg::OPC_ROR, 3'd2, 3'd1},
    {trs_pkg::OPC_ROR, 3'd3, 3'd1}, {trs_pkg::OPC_ROR, 3'd4, 3'd1},
    {trs_pkg::OPC_RSB, 3'd5, 3'd5}, {trs_pkg::OPC_RSB, 3'd4, 3'd3},
    {trs_pkg::OPC_SBC, 3'd7, 3'd6}, {trs_pkg::OPC_SBC, 3'd7, 3'd6}};
  localparam logic [31:0] PRE [7] = '{32'h1000_0000, 32'h1000_0000, 32'h3000_0000,
    32'h0, 32'h7000_0000, 32'h0, 32'h2000_0000};
  localparam int IDX [7] = '{1, 1, 1, 5, 3, 6, 6};
  localparam logic [31:0] VAL [7] = '{32'h8000_0008, 32'h8000_0008, 32'h4000_0004,
    32'h8000_0000, 32'hffff_ffdf, 32'h0000_0001, 32'hffff_fffe};
  localparam logic [31:0] FLG [7] = '{32'hb000_0000, 32'h9000_0000, 32'h1000_0000,
    32'h9000_0000, 32'h8000_0000, 32'h2000_0000, 32'h8000_0000};
  localparam logic [31:0] INI [8] = '{32'h1000, 32'h11, 32'hf01, 32'h100, 32'h21,
    32'h8000_0000, 32'h5, 32'h3};
  localparam logic [31:0] EA [5] = '{32'h1000, 32'h1004, 32'h1008, 32'h1088, 32'h23fc};
  localparam logic [31:0] ED [5] = '{32'h4000_0004, 32'h0000_0f01, 32'hffff_fffe,
    32'h8000_0000, 32'h0000_0003};

  trs_exec DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .event_out(event_out));
  trs_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .stall(stall));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (event_out === 1'b1) ev_cnt <= ev_cnt + 1;

  function automatic logic [7:0] ga(input int i);
    return {trs_pkg::GPR_PAGE, i[3:0], 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Both responses are always accepted, so only the request side is driven here.
  // Waits are open ended here; only the watchdog ends a stuck handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask
  task automatic ex(input logic [15:0] ins);
    wr(trs_pkg::OFF_INSTR, {16'h0000, ins});
    do begin
      rd(trs_pkg::OFF_STATUS);
    end while (v[trs_pkg::STAT_BUSY] !== 1'b0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    test_done();
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid, stall} = '0;
    n_fail = 0;
    checked = 0;
    ev_cnt = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(trs_pkg::OFF_FLAGS);
    chk("flags reset", v, 32'h0);
    for (int i = 0; i < 8; i++) wr(ga(i), INI[i]);
    wr(ga(13), 32'h2000);
    chk("write resp", {30'h0, r}, {30'h0, trs_pkg::RESP_OKAY});
    for (int i = 0; i < 7; i++) begin
      wr(trs_pkg::OFF_FLAGS, PRE[i]);
      ex(INS[i]);
      rd(ga(IDX[i]));
      chk("alu result", v, VAL[i]);
      rd(trs_pkg::OFF_FLAGS);
      chk("alu flags", v, FLG[i]);
    end
    ex(trs_pkg::OPC_SEV);
    chk("event count", ev_cnt, 32'h1);
    rd(trs_pkg::OFF_STATUS);
    chk("status", v, 32'h4);
    rd(trs_pkg::OFF_FLAGS);
    chk("flags kept", v, 32'h8000_0000);
    chk("no store", u_mem.addr_q.size(), 32'h0);
    rd(ga(6));
    chk("regs kept", v, 32'hffff_fffe);
    // Clearing the event record first lets the undefined flag stand alone.
    wr(trs_pkg::OFF_STATUS, 32'h1 << trs_pkg::STAT_EVENT);
    ex(16'h0000);
    rd(trs_pkg::OFF_STATUS);
    chk("undef status", v, 32'h1 << trs_pkg::STAT_UNDEF);
    // A slow memory makes each listed word wait; the list is never empty.
    stall <= 4'd3;
    ex({trs_pkg::OPC_STM, 3'd0, 8'h46});
    rd(ga(0));
    chk("base writeback", v, 32'h100c);
    stall <= 4'd0;
    ex({trs_pkg::OPC_STR_REG_BASE, 5'd31, 3'd0, 3'd5});
    rd(ga(0));
    chk("base kept", v, 32'h100c);
    ex({trs_pkg::OPC_STR_SP_BASE, 3'd7, 8'hff});
    rd(ga(13));
    chk("sp kept", v, 32'h2000);
    chk("store count", u_mem.addr_q.size(), 32'h5);
    for (int i = 0; i < 5 && i < u_mem.addr_q.size(); i++) begin
      chk("store addr", u_mem.addr_q[i], EA[i]);
      chk("store data", u_mem.data_q[i], ED[i]);
    end
    rd(8'h0c);
    chk("unmapped read", {30'h0, r}, {30'h0, trs_pkg::RESP_SLVERR});
    wr(8'h0c, 32'h1);
    chk("unmapped write", {30'h0, r}, {30'h0, trs_pkg::RESP_SLVERR});
    test_done();
  end
endmodule // trs_exec_tb_top

`default_nettype wire
